// file: common/fall_motion_consts.vh
/*
  Register offsets, field positions, reset values and widths for the freefall
  and motion detector. Assumes it is included by bare name from the hw/ files.
*/
`ifndef FALL_MOTION_CONSTS_VH
`define FALL_MOTION_CONSTS_VH

// ---------------------------------------------------------------------------
// Register map
// ---------------------------------------------------------------------------
`define FM_ADDR_W 8
`define FM_DATA_W 8
`define FM_OFS_CONFIG 8'h15
`define FM_OFS_SOURCE 8'h16
`define FM_OFS_THRESHOLD 8'h17
`define FM_OFS_DEBOUNCE_COUNT 8'h18
`define FM_OFS_IRQ_CTRL 8'h19

// ---------------------------------------------------------------------------
// Configuration register fields
// ---------------------------------------------------------------------------
`define FM_CFG_LATCH_BIT 7
`define FM_CFG_COMBINE_BIT 6
`define FM_CFG_EN_LSB 3
`define FM_CFG_EN_MSB 5
`define FM_CFG_RESET 8'h00

// ---------------------------------------------------------------------------
// Source register fields
// ---------------------------------------------------------------------------
`define FM_SRC_ACTIVE_BIT 7
`define FM_SRC_RESET 8'h00

// ---------------------------------------------------------------------------
// Threshold and debounce fields
// ---------------------------------------------------------------------------
`define FM_THS_CLEAR_MODE_BIT 7
`define FM_THS_MSB 6
`define FM_THS_W 7
`define FM_THS_RESET 7'h00
`define FM_CNT_W 8
`define FM_CNT_RESET 8'h00
`define FM_CNT_ONE 8'h01

// ---------------------------------------------------------------------------
// Interrupt control fields
// ---------------------------------------------------------------------------
`define FM_IRQ_ENABLE_BIT 0
`define FM_IRQ_ROUTE_BIT 1

// ---------------------------------------------------------------------------
// Axis data
// ---------------------------------------------------------------------------
`define FM_AXES 3
`define FM_ACC_W 8
`define FM_MAG_W 8

`endif

// file: hw/axis_compare.v
/*
  One axis comparator: magnitude of a signed sample against the threshold,
  with the sign as polarity. Assumes samples are scaled so one count equals
  one threshold count.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fall_motion_consts.vh"

module axis_compare (
  input wire [`FM_ACC_W-1:0] sample,
  input wire [`FM_THS_W-1:0] threshold,
  output wire above,
  output wire negative
);

  wire [`FM_MAG_W-1:0] magnitude;

  // The most negative sample gives a magnitude of 128, still above any threshold.
  assign magnitude = sample[`FM_ACC_W-1] ? (~sample + 8'h01) : sample;
  assign above = magnitude > {1'b0, threshold};
  assign negative = sample[`FM_ACC_W-1];

endmodule // axis_compare
`default_nettype wire

// file: hw/debounce_counter.v
/*
  Debounce counter for the freefall and motion event. Assumes step pulses
  once per output data sample and clear comes from a latched source read.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fall_motion_consts.vh"

module debounce_counter (
  input wire core_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire step,
  input wire clear,
  input wire cond,
  input wire clear_mode,
  input wire [`FM_CNT_W-1:0] target,
  output reg [`FM_CNT_W-1:0] count_q,
  output wire reach_d
);

  reg [`FM_CNT_W-1:0] count_d;
  reg [`FM_CNT_W-1:0] base;

  always @* begin
    base = clear ? `FM_CNT_RESET : count_q;
    count_d = base;
    if (step) begin
      if (cond) begin
        if (base < target) begin
          count_d = base + `FM_CNT_ONE;
        end
      end else if (clear_mode) begin
        count_d = `FM_CNT_RESET;
      end else if (base != `FM_CNT_RESET) begin
        count_d = base - `FM_CNT_ONE;
      end
    end
  end

  assign reach_d = step && cond && (count_d == target);

  always @(posedge core_clk) begin
    if (sys_rst) begin
      count_q <= `FM_CNT_RESET;
    end else if (clk_en) begin
      count_q <= count_d;
    end
  end

endmodule // debounce_counter
`default_nettype wire

// file: hw/fall_motion_detector.v
/*
  Freefall and motion detector with its register file and interrupt routing.
  Assumes sample_valid pulses once per output data sample on core_clk and
  that the axis samples come from logic on the same clock.
*/
// The strobed register port was chosen for this implementation.
// Function
// - Latched motion: active flag holds until read
// - Latched read clears source and debounce counter
// - Inactive flag shows live, undebounced axis flags
// - Latched active: axis flags hold until read
// - Latch enable bit selects latched source
// - Combine select: 0 AND freefall, 1 OR
// - Per-axis enable bits gate detection
// - Latched: freeze source, block newer results
// - Unlatched: source follows real-time status
// - Freefall: all enabled magnitudes at most threshold
// - Motion: any enabled magnitude above threshold
// - Source layout: active, zero, Z/Y/X pairs
// - Active flag set by configured combination
// - Disabled axis flags read zero
// - Polarity: 0 positive, 1 negative
// - Interrupt from active flag, enable, route
// - Counter counts matches, saturates at count
// - Lapse: clear or decrement per mode
// - Threshold 7 bits, 0 to 127 counts
// - Unlatched read clears nothing
`timescale 1ns/10ps
`default_nettype none
`include "fall_motion_consts.vh"

module fall_motion_detector (
  input wire core_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire sample_valid,
  input wire [`FM_ACC_W-1:0] accel_x,
  input wire [`FM_ACC_W-1:0] accel_y,
  input wire [`FM_ACC_W-1:0] accel_z,
  input wire [`FM_ADDR_W-1:0] reg_addr,
  input wire [`FM_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`FM_DATA_W-1:0] reg_rdata,
  output reg irq_line1,
  output reg irq_line2
);

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  reg event_latch_enable_q;
  reg combine_select_q;
  reg [`FM_AXES-1:0] axis_enable_q;
  reg debounce_clear_mode_q;
  reg [`FM_THS_W-1:0] threshold_q;
  reg [`FM_CNT_W-1:0] debounce_target_q;
  reg fall_motion_irq_enable_q;
  reg fall_motion_irq_route_q;

  wire wr_config;
  wire wr_threshold;
  wire wr_count;
  wire wr_irq;

  assign wr_config = reg_wr && (reg_addr == `FM_OFS_CONFIG);
  assign wr_threshold = reg_wr && (reg_addr == `FM_OFS_THRESHOLD);
  assign wr_count = reg_wr && (reg_addr == `FM_OFS_DEBOUNCE_COUNT);
  assign wr_irq = reg_wr && (reg_addr == `FM_OFS_IRQ_CTRL);

  always @(posedge core_clk) begin
    if (sys_rst) begin
      event_latch_enable_q <= 1'b0;
      combine_select_q <= 1'b0;
      axis_enable_q <= 3'h0;
      debounce_clear_mode_q <= 1'b0;
      threshold_q <= `FM_THS_RESET;
      debounce_target_q <= `FM_CNT_RESET;
      fall_motion_irq_enable_q <= 1'b0;
      fall_motion_irq_route_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_config) begin
        event_latch_enable_q <= reg_wdata[`FM_CFG_LATCH_BIT];
        combine_select_q <= reg_wdata[`FM_CFG_COMBINE_BIT];
        axis_enable_q <= reg_wdata[`FM_CFG_EN_MSB:`FM_CFG_EN_LSB];
      end
      if (wr_threshold) begin
        debounce_clear_mode_q <= reg_wdata[`FM_THS_CLEAR_MODE_BIT];
        threshold_q <= reg_wdata[`FM_THS_MSB:0];
      end
      if (wr_count) begin
        debounce_target_q <= reg_wdata;
      end
      if (wr_irq) begin
        fall_motion_irq_enable_q <= reg_wdata[`FM_IRQ_ENABLE_BIT];
        fall_motion_irq_route_q <= reg_wdata[`FM_IRQ_ROUTE_BIT];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Per-axis comparison
  // ---------------------------------------------------------------------------
  // Axis index 0 is X, 1 is Y, 2 is Z, matching the enable field order.
  wire [3*`FM_ACC_W-1:0] accel_all;
  wire [`FM_AXES-1:0] axis_above;
  wire [`FM_AXES-1:0] axis_negative;
  wire [`FM_AXES-1:0] live_event;
  wire [`FM_AXES-1:0] live_polarity;

  assign accel_all = {accel_z, accel_y, accel_x};

  genvar g;
  generate
    for (g = 0; g < `FM_AXES; g = g + 1) begin : axis
      axis_compare cmp (
        .sample(accel_all[g*`FM_ACC_W +: `FM_ACC_W]),
        .threshold(threshold_q),
        .above(axis_above[g]),
        .negative(axis_negative[g])
      );
      assign live_event[g] = axis_enable_q[g] && axis_above[g];
      assign live_polarity[g] = axis_enable_q[g] && axis_above[g] && axis_negative[g];
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Combined condition
  // ---------------------------------------------------------------------------
  wire any_enabled;
  wire motion_cond;
  wire freefall_cond;
  wire combined_cond;

  assign any_enabled = |axis_enable_q;
  assign motion_cond = |live_event;
  // all enabled axes at or below
  assign freefall_cond = any_enabled && ((axis_above & axis_enable_q) == 3'h0);
  assign combined_cond = combine_select_q ? motion_cond : freefall_cond;

  // ---------------------------------------------------------------------------
  // Debounce
  // ---------------------------------------------------------------------------
  wire src_read;
  wire latched_clear;
  wire [`FM_CNT_W-1:0] debounce_count;
  wire reach_d;

  assign src_read = reg_rd && (reg_addr == `FM_OFS_SOURCE);
  assign latched_clear = src_read && event_latch_enable_q;

  debounce_counter dbc (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .step(sample_valid),
    .clear(latched_clear),
    .cond(combined_cond),
    .clear_mode(debounce_clear_mode_q),
    .target(debounce_target_q),
    .count_q(debounce_count),
    .reach_d(reach_d)
  );

  // ---------------------------------------------------------------------------
  // Event active flag and source flags
  // ---------------------------------------------------------------------------
  reg event_active_q;
  reg event_active_d;
  reg [`FM_AXES-1:0] event_flag_q;
  reg [`FM_AXES-1:0] event_flag_d;
  reg [`FM_AXES-1:0] polarity_flag_q;
  reg [`FM_AXES-1:0] polarity_flag_d;
  reg active_base;
  reg [`FM_AXES-1:0] event_base;
  reg [`FM_AXES-1:0] polarity_base;
  reg frozen;

  always @* begin
    // a latched read clears every source bit before the new sample applies
    active_base = latched_clear ? 1'b0 : event_active_q;
    event_base = latched_clear ? 3'h0 : event_flag_q;
    polarity_base = latched_clear ? 3'h0 : polarity_flag_q;
    frozen = event_latch_enable_q && active_base;
    event_active_d = active_base;
    event_flag_d = event_base;
    polarity_flag_d = polarity_base;
    if (sample_valid) begin
      if (event_latch_enable_q) begin
        // set on reach, hold until read
        if (reach_d) begin
          event_active_d = 1'b1;
        end
      end else if (combined_cond) begin
        event_active_d = reach_d || (active_base && debounce_count == debounce_target_q);
      end else begin
        event_active_d = active_base && !debounce_clear_mode_q && (debounce_count > `FM_CNT_ONE);
      end
      if (!frozen) begin
        event_flag_d = live_event;
        polarity_flag_d = live_polarity;
      end
    end
  end

  // Clearing is applied first, so an event reaching in the read cycle still sets.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      event_active_q <= 1'b0;
      event_flag_q <= 3'h0;
      polarity_flag_q <= 3'h0;
    end else if (clk_en) begin
      event_active_q <= event_active_d;
      event_flag_q <= event_flag_d;
      polarity_flag_q <= polarity_flag_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Source register view
  // ---------------------------------------------------------------------------
  wire [`FM_AXES-1:0] shown_event;
  wire [`FM_AXES-1:0] shown_polarity;
  wire [`FM_DATA_W-1:0] source_value;

  assign shown_event = event_flag_q & axis_enable_q;
  assign shown_polarity = polarity_flag_q & axis_enable_q;
  assign source_value = {event_active_q, 1'b0,
                         shown_event[2], shown_polarity[2],
                         shown_event[1], shown_polarity[1],
                         shown_event[0], shown_polarity[0]};

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  reg [`FM_DATA_W-1:0] read_mux;

  always @* begin
    case (reg_addr)
      `FM_OFS_CONFIG: begin
        read_mux = {event_latch_enable_q, combine_select_q, axis_enable_q, 3'h0};
      end
      `FM_OFS_SOURCE: begin
        read_mux = source_value;
      end
      `FM_OFS_THRESHOLD: begin
        read_mux = {debounce_clear_mode_q, threshold_q};
      end
      `FM_OFS_DEBOUNCE_COUNT: begin
        read_mux = debounce_target_q;
      end
      `FM_OFS_IRQ_CTRL: begin
        read_mux = {6'h00, fall_motion_irq_route_q, fall_motion_irq_enable_q};
      end
      default: begin
        read_mux = 8'h00;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe and are zero otherwise.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? read_mux : 8'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt routing
  // ---------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      irq_line1 <= 1'b0;
      irq_line2 <= 1'b0;
    end else if (clk_en) begin
      irq_line1 <= event_active_d && fall_motion_irq_enable_q && fall_motion_irq_route_q;
      irq_line2 <= event_active_d && fall_motion_irq_enable_q && !fall_motion_irq_route_q;
    end
  end

endmodule // fall_motion_detector
`default_nettype wire

// file: testbench/fall_motion_monitor.sv
/*
  Port checker for the freefall and motion detector.
  Assumes the register map of fall_motion_consts.vh and one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fall_motion_consts.vh"

module fall_motion_monitor (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic sample_valid,
  input wire logic [7:0] accel_x,
  input wire logic [7:0] accel_y,
  input wire logic [7:0] accel_z,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_line1,
  input wire logic irq_line2
);
  // ---------------------------------------------------------------------
  // Shadow of the configuration register
  // ---------------------------------------------------------------------
  logic [7:0] cfg_q;
  logic [5:0] en_mask;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_q <= 8'h00;
    end else if (clk_en && reg_wr && reg_addr == 8'h15) begin
      cfg_q <= reg_wdata;
    end
  end
  assign en_mask = {{2{cfg_q[5]}}, {2{cfg_q[4]}}, {2{cfg_q[3]}}};

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------
  sequence src_rd;
    clk_en && reg_rd && reg_addr == 8'h16;
  endsequence
  // A sample in the read cycle would be applied after the clear.
  sequence quiet_rd;
    src_rd ##0 !sample_valid;
  endsequence

  a_src_bit6_zero: assert property (src_rd |=> !reg_rdata[6])
    else $error("source bit 6 read as one");
  a_latched_read_clear: assert property (cfg_q[7] ##0 quiet_rd ##1 src_rd |=> reg_rdata == 8'h00)
    else $error("latched source not cleared by read");
  a_unlatched_read_keeps: assert property (!cfg_q[7] ##0 quiet_rd ##1 src_rd |=> reg_rdata == $past(reg_rdata))
    else $error("unlatched source changed by read");
  a_disabled_axis_zero: assert property (src_rd |=> (reg_rdata[5:0] & ~$past(en_mask)) == 6'h00)
    else $error("disabled axis flag read as one");
  a_polarity_needs_event: assert property (src_rd |=>
      reg_rdata[4] <= reg_rdata[5] && reg_rdata[2] <= reg_rdata[3] && reg_rdata[0] <= reg_rdata[1])
    else $error("polarity flag without event flag");
  a_irq_one_line: assert property (!(irq_line1 && irq_line2))
    else $error("both interrupt lines high");
  a_irq_from_active: assert property (src_rd ##0 (irq_line1 || irq_line2) |=> reg_rdata[7])
    else $error("interrupt high while event inactive");
  a_latched_active_hold: assert property (cfg_q[7] && (irq_line1 || irq_line2) && !reg_wr
      && !(reg_rd && reg_addr == 8'h16) |=> irq_line1 || irq_line2)
    else $error("latched event dropped without read");
endmodule // fall_motion_monitor

bind fall_motion_detector fall_motion_monitor u_mon (
  .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .sample_valid(sample_valid),
  .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq_line1(irq_line1), .irq_line2(irq_line2)
);
`default_nettype wire

// file: testbench/testbench.sv
/*
  Self-checking bench for the freefall and motion detector.
  Assumes the register map of fall_motion_consts.vh and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fall_motion_consts.vh"

module testbench;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic sample_valid = 1'b0;
  logic [7:0] accel_x = 8'h00;
  logic [7:0] accel_y = 8'h00;
  logic [7:0] accel_z = 8'h00;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire [7:0] reg_rdata;
  wire irq_line1;
  wire irq_line2;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;

  always #5 core_clk = ~core_clk;

  fall_motion_detector DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .sample_valid(sample_valid),
    .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_line1(irq_line1), .irq_line2(irq_line2)
  );

  // ---------------------------------------------------------------------
  // Bus and sample tasks
  // ---------------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  // Two reads back to back when both is set, so the second sees the first's effect.
  task automatic rd2(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1, input bit both);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    if (!both) begin
      reg_rd <= 1'b0;
    end
    @(negedge core_clk);
    chk($sformatf("reg %h", a), reg_rdata, e0);
    @(posedge core_clk);
    if (both) begin
      reg_rd <= 1'b0;
      @(negedge core_clk);
      chk($sformatf("reg %h again", a), reg_rdata, e1);
      @(posedge core_clk);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd2(a, e, e, 1'b0);
  endtask

  task automatic smp(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
    accel_x <= x;
    accel_y <= y;
    accel_z <= z;
    sample_valid <= 1'b1;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic irqs(input logic [7:0] e);
    @(negedge core_clk);
    chk("irq lines", {6'h00, irq_line2, irq_line1}, e);
    @(posedge core_clk);
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      final_report();
    end
  end

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 8'h14; i <= 8'h1a; i++) rd(i[7:0], 8'h00);
    wr(8'h15, 8'hff);
    wr(8'h16, 8'hff);
    rd(8'h15, 8'hf8);
    rd(8'h16, 8'h00);
    // Unlatched motion, clear mode, threshold 16, count 2, line one.
    wr(8'h15, 8'h78);
    wr(8'h17, 8'h90);
    wr(8'h18, 8'h02);
    wr(8'h19, 8'h03);
    smp(8'h11, 8'h00, 8'h00);
    rd(8'h16, 8'h02);
    smp(8'h11, 8'h00, 8'hf0);
    rd(8'h16, 8'h82);
    irqs(8'h01);
    smp(8'h00, 8'h00, 8'hef);
    rd2(8'h16, 8'hb0, 8'hb0, 1'b1);
    smp(8'h00, 8'h00, 8'h00);
    rd(8'h16, 8'h00);
    irqs(8'h00);
    // Decrement mode: the counter must saturate at the target.
    wr(8'h17, 8'h10);
    repeat (3) smp(8'h11, 8'h00, 8'h00);
    smp(8'h00, 8'h00, 8'h00);
    rd(8'h16, 8'h80);
    smp(8'h00, 8'h00, 8'h00);
    rd(8'h16, 8'h00);
    // Latched motion.
    wr(8'h15, 8'hf8);
    wr(8'h17, 8'h90);
    smp(8'hec, 8'h00, 8'h00);
    smp(8'hec, 8'h00, 8'h00);
    smp(8'h00, 8'h1e, 8'h00);
    rd2(8'h16, 8'h83, 8'h00, 1'b1);
    smp(8'h00, 8'h1e, 8'h00);
    irqs(8'h00);
    smp(8'h00, 8'h1e, 8'h00);
    rd(8'h16, 8'h88);
    // Unlatched freefall on x and y, count 1, line two.
    wr(8'h19, 8'h01);
    wr(8'h15, 8'h18);
    wr(8'h18, 8'h01);
    smp(8'h10, 8'hf0, 8'h64);
    irqs(8'h02);
    rd(8'h16, 8'h80);
    wr(8'h19, 8'h00);
    irqs(8'h00);
    smp(8'h11, 8'h00, 8'h00);
    rd(8'h16, 8'h02);
    wr(8'h15, 8'h10);
    rd(8'h16, 8'h00);
    wr(8'h15, 8'h00);
    smp(8'h00, 8'h00, 8'h00);
    rd(8'h16, 8'h00);
    // A write while the clock enable is low must leave the threshold untouched.
    clk_en <= 1'b0;
    wr(8'h17, 8'h55);
    clk_en <= 1'b1;
    rd(8'h17, 8'h90);
    final_report();
  end
endmodule // testbench
`default_nettype wire
